// ### core/dual_counter_pkg.sv
`default_nettype none

package dual_counter_pkg;

    localparam int          CNT_W       = 16;
    localparam int          BYTE_W      = 8;
    localparam int          AXI_DW      = 32;
    localparam int          AXI_AW      = 4;
    localparam int          PIN_W       = 9;

    // Register byte addresses
    localparam logic [3:0]  OFF_CTRL    = 4'h0;
    localparam logic [3:0]  OFF_STATUS  = 4'h4;
    localparam logic [3:0]  OFF_COUNT   = 4'h8;
    localparam logic [3:0]  OFF_STORE   = 4'hC;

    // Control and status field positions
    localparam int          CTRL_CLEAR_BIT   = 0;
    localparam int          CTRL_CAPTURE_BIT = 1;
    localparam int          ST_DRIVEN_BIT    = 0;
    localparam int          ST_CONFLICT_BIT  = 1;
    localparam int          ST_CLEAR_BIT     = 2;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [15:0] CNT_TERM    = 16'hFFFF;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

    // Pin idle: clocks low, enable off, clear held, selects high
    localparam logic [8:0]  PIN_RST     = 9'h02F;

    typedef struct packed {
        logic capture_clock;
        logic count_a_clock;
        logic count_b_clock;
        logic count_b_enable_n;
        logic counter_clear_n;
        logic sel_a_low_byte_n;
        logic sel_a_high_byte_n;
        logic sel_b_low_byte_n;
        logic sel_b_high_byte_n;
    } pin_in_t;

endpackage

`default_nettype wire

// ### core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // First stage feeds only the second stage
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

`default_nettype wire

// ### core/dual_counter.sv
// Operation
// - Two independent 16-bit counters, byte output floatable
// - Each counter has split 16-bit storage register
// - Each counter advances on its clock's rise
// - Capture edge loads both storage registers together
// - Single low select picks byte; none floats
// - B counts only when enable low at edge
// - Counting resumes only after clear released
`timescale 1ns/1ps
`default_nettype none

module dual_counter (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          count_a_clock,
    input  wire logic                          count_b_clock,
    input  wire logic                          capture_clock,
    input  wire logic                          count_b_enable_n,
    input  wire logic                          counter_clear_n,
    input  wire logic                          sel_a_low_byte_n,
    input  wire logic                          sel_a_high_byte_n,
    input  wire logic                          sel_b_low_byte_n,
    input  wire logic                          sel_b_high_byte_n,
    output logic [dual_counter_pkg::BYTE_W-1:0] byte_out_bus,
    output logic                               byte_out_oe,
    output logic                               carry_out_a_n,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [dual_counter_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [dual_counter_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [dual_counter_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [dual_counter_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0]                         s_axi_rresp
);
    import dual_counter_pkg::*;

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        is_mapped = (a == OFF_CTRL) || (a == OFF_STATUS) ||
                    (a == OFF_COUNT) || (a == OFF_STORE);
    endfunction

    // ---------------- Pin sampling ----------------
    pin_in_t     raw;
    pin_in_t     s;
    pin_in_t     prev_r;
    assign raw = '{capture_clock, count_a_clock, count_b_clock,
                   count_b_enable_n, counter_clear_n, sel_a_low_byte_n,
                   sel_a_high_byte_n, sel_b_low_byte_n, sel_b_high_byte_n};

    pin_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    (raw),
        .q    (s)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) prev_r <= PIN_RST;
        else     prev_r <= s;
    end

    // ---------------- Counters ----------------
    logic [CNT_W-1:0] cnt_a_r;
    logic [CNT_W-1:0] cnt_b_r;
    logic [CNT_W-1:0] store_a_r;
    logic [CNT_W-1:0] store_b_r;
    logic             soft_clear_r;
    logic             soft_cap_r;

    wire        edge_a   = s.count_a_clock & ~prev_r.count_a_clock;
    wire        edge_b   = s.count_b_clock & ~prev_r.count_b_clock;
    wire        edge_cap = s.capture_clock & ~prev_r.capture_clock;
    wire        cap_evt  = edge_cap | soft_cap_r;
    wire        clr      = ~s.counter_clear_n | soft_clear_r;
    wire        step_b   = edge_b & ~s.count_b_enable_n;
    // Clear beats any count edge in the same cycle
    wire [CNT_W-1:0] cnt_a_nxt = clr ? CNT_ZERO :
                                 edge_a ? cnt_a_r + CNT_ONE : cnt_a_r;
    wire [CNT_W-1:0] cnt_b_nxt = clr ? CNT_ZERO :
                                 step_b ? cnt_b_r + CNT_ONE : cnt_b_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_a_r       <= CNT_ZERO;
            cnt_b_r       <= CNT_ZERO;
            carry_out_a_n <= 1'b1;
        end else begin
            cnt_a_r       <= cnt_a_nxt;
            cnt_b_r       <= cnt_b_nxt;
            carry_out_a_n <= ~(cnt_a_nxt == CNT_TERM);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            store_a_r <= CNT_ZERO;
            store_b_r <= CNT_ZERO;
        end else if (cap_evt) begin
            store_a_r <= cnt_a_r;
            store_b_r <= cnt_b_r;
        end
    end

    // ---------------- Byte output ----------------
    wire [3:0] sel_low = ~{s.sel_a_low_byte_n, s.sel_a_high_byte_n,
                           s.sel_b_low_byte_n, s.sel_b_high_byte_n};
    wire [3:0] sel_rest = sel_low - 4'h1;
    wire       conflict = (sel_low & sel_rest) != 4'h0;
    wire       oe_nxt   = sel_low != 4'h0;
    // Overlapping selects resolve by priority; data is not promised then
    wire [BYTE_W-1:0] byte_nxt =
        sel_low[3] ? store_a_r[7:0]  :
        sel_low[2] ? store_a_r[15:8] :
        sel_low[1] ? store_b_r[7:0]  :
        sel_low[0] ? store_b_r[15:8] : BYTE_ZERO;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            byte_out_bus <= BYTE_ZERO;
            byte_out_oe  <= 1'b0;
        end else begin
            byte_out_bus <= byte_nxt;
            byte_out_oe  <= oe_nxt;
        end
    end

    // ---------------- AXI4-Lite slave ----------------
    logic              aw_got_r;
    logic              w_got_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [AXI_DW-1:0] wdata_r;
    logic              wstrb0_r;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire ar_take  = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_got_r & w_got_r;
    wire wr_ok    = is_mapped(awaddr_r);
    wire wr_ctrl  = do_write & (awaddr_r == OFF_CTRL) & wstrb0_r;
    wire aw_nxt   = ~do_write & (aw_got_r | aw_take);
    wire w_nxt    = ~do_write & (w_got_r | w_take);
    wire bv_nxt   = do_write | (s_axi_bvalid & ~s_axi_bready);
    wire rv_nxt   = ar_take | (s_axi_rvalid & ~s_axi_rready);

    wire [AXI_DW-1:0] status_w = {29'h0000_0000, clr, conflict, oe_nxt};
    wire [AXI_DW-1:0] rd_mux =
        (s_axi_araddr == OFF_CTRL)   ? {31'h0000_0000, soft_clear_r} :
        (s_axi_araddr == OFF_STATUS) ? status_w :
        (s_axi_araddr == OFF_COUNT)  ? {cnt_b_r, cnt_a_r} :
        (s_axi_araddr == OFF_STORE)  ? {store_b_r, store_a_r} : WORD_ZERO;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 4'h0;
            wdata_r       <= WORD_ZERO;
            wstrb0_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_got_r      <= aw_nxt;
            w_got_r       <= w_nxt;
            s_axi_awready <= ~aw_nxt & ~bv_nxt;
            s_axi_wready  <= ~w_nxt & ~bv_nxt;
            s_axi_bvalid  <= bv_nxt;
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (do_write) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Capture request is a one-cycle pulse; clear is a held level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            soft_clear_r <= 1'b0;
            soft_cap_r   <= 1'b0;
        end else begin
            soft_cap_r <= wr_ctrl & wdata_r[CTRL_CAPTURE_BIT];
            if (wr_ctrl) soft_clear_r <= wdata_r[CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= WORD_ZERO;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rv_nxt;
            s_axi_rvalid  <= rv_nxt;
            if (ar_take) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY
                                                       : RESP_SLVERR;
            end
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_wrap;
        (cnt_a_r == CNT_TERM) && edge_a && !clr |=> cnt_a_r == CNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter A did not wrap to zero");

    property p_a_step;
        edge_a && !clr |=> cnt_a_r == $past(cnt_a_r) + CNT_ONE;
    endproperty
    a_a_step: assert property (p_a_step)
        else $error("counter A missed a count edge");

    property p_a_hold;
        !edge_a && !clr |=> $stable(cnt_a_r);
    endproperty
    a_a_hold: assert property (p_a_hold)
        else $error("counter A moved without an edge");

    property p_b_gate;
        !clr && edge_b && s.count_b_enable_n |=> $stable(cnt_b_r);
    endproperty
    a_b_gate: assert property (p_b_gate)
        else $error("counter B moved while disabled");

    property p_b_step;
        !clr && step_b |=> cnt_b_r == $past(cnt_b_r) + CNT_ONE;
    endproperty
    a_b_step: assert property (p_b_step)
        else $error("counter B missed an enabled edge");

    property p_capture;
        cap_evt |=> store_a_r == $past(cnt_a_r) &&
                    store_b_r == $past(cnt_b_r);
    endproperty
    a_capture: assert property (p_capture)
        else $error("storage did not load both counts");

    property p_float;
        sel_low == 4'h0 |=> !byte_out_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("bus driven with no select low");

    property p_a_high;
        sel_low == 4'h4 |=> byte_out_oe &&
                            byte_out_bus == $past(store_a_r[15:8]);
    endproperty
    a_a_high: assert property (p_a_high)
        else $error("wrong byte for A upper select");

    property p_clear;
        clr ##1 clr |-> cnt_a_r == CNT_ZERO && cnt_b_r == CNT_ZERO;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counters not held at zero in clear");

    property p_resume;
        clr && (edge_a || step_b) |=> cnt_a_r == CNT_ZERO &&
                                      cnt_b_r == CNT_ZERO;
    endproperty
    a_resume: assert property (p_resume)
        else $error("counted while clear was active");

    property p_carry;
        !carry_out_a_n == (cnt_a_r == CNT_TERM);
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry out does not match terminal count");

    c_wrap:     cover property (edge_a && cnt_a_r == CNT_TERM && step_b);
    c_capture:  cover property (edge_cap ##[1:20] sel_low == 4'h8);
    c_conflict: cover property (conflict);
    c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

`default_nettype wire

// ### testbench/byte_reader.sv
`timescale 1ns/1ps
`default_nettype none

module byte_reader (
    input  wire logic                           mclk,
    input  wire logic                           carry_out_a_n,
    input  wire logic [dual_counter_pkg::BYTE_W-1:0] byte_out_bus,
    input  wire logic                           byte_out_oe,
    output var  dual_counter_pkg::pin_in_t      pins,
    output logic [dual_counter_pkg::BYTE_W-1:0] bus_seen
);
    import dual_counter_pkg::*;
    pin_in_t           pins_r;
    logic              chain_on;
    logic [BYTE_W-1:0] last_r;

    initial begin
        pins_r = PIN_RST;
        chain_on = 1'b0;
    end

    always_comb begin
        pins = pins_r;
        if (chain_on) begin
            pins.count_b_enable_n = carry_out_a_n;
        end
    end

    // Released bus must not echo the last byte
    always @(posedge mclk) begin
        if (byte_out_oe) begin
            last_r <= byte_out_bus;
        end
    end
    assign bus_seen = byte_out_oe ? byte_out_bus : ~last_r;

    // Phases of five cycles let the chained carry settle
    task automatic pulse(input logic [PIN_W-1:0] mask);
        @(posedge mclk);
        pins_r <= pins_r | mask;
        repeat (5) @(posedge mclk);
        pins_r <= pins_r & ~mask;
        repeat (5) @(posedge mclk);
    endtask

    task automatic set_level(input int idx, input logic v);
        @(posedge mclk);
        pins_r[idx] <= v;
        repeat (4) @(posedge mclk);
    endtask

    task automatic read_byte(input int idx, output logic [BYTE_W-1:0] v);
        @(posedge mclk);
        pins_r[idx] <= 1'b0;
        repeat (5) @(posedge mclk);
        v = bus_seen;
        pins_r[idx] <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask
endmodule

`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dual_counter_pkg::*;
    logic              mclk, rst, byte_out_oe, carry_out_a_n;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
    logic [BYTE_W-1:0] byte_out_bus, bus_seen, bval;
    logic [BYTE_W-1:0] exp_b [4] = '{8'h03, 8'h00, 8'h02, 8'h00};
    pin_in_t           pins;
    int                mismatches, cmp_count, cyc;
    logic              capture_clock, count_a_clock, count_b_clock;
    logic              count_b_enable_n, counter_clear_n;
    logic              sel_a_low_byte_n, sel_a_high_byte_n;
    logic              sel_b_low_byte_n, sel_b_high_byte_n;

    // Unpack the reader's pin bundle into the block's own pins
    assign {capture_clock, count_a_clock, count_b_clock, count_b_enable_n,
            counter_clear_n, sel_a_low_byte_n, sel_a_high_byte_n,
            sel_b_low_byte_n, sel_b_high_byte_n} = pins;

    dual_counter DUT (
        .mclk, .rst, .byte_out_bus, .byte_out_oe, .carry_out_a_n,
        .count_a_clock, .count_b_clock, .capture_clock, .count_b_enable_n,
        .counter_clear_n, .sel_a_low_byte_n, .sel_a_high_byte_n,
        .sel_b_low_byte_n, .sel_b_high_byte_n,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp
    );

    byte_reader rdr (
        .mclk, .carry_out_a_n, .byte_out_bus, .byte_out_oe, .pins, .bus_seen
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs well under two thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check_val(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic axi_write(input logic [AXI_AW-1:0] a,
                             input logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    task automatic axi_read(input logic [AXI_AW-1:0] a,
                            output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    task automatic reg_expect(input logic [AXI_AW-1:0] a,
                              input logic [31:0] e);
        axi_read(a, rd, rsp);
        check_val($sformatf("reg %h", a), e, rd);
        check_val("read resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    endtask

    initial begin
        rst = 1'b1;
        cyc = 0;
        mismatches = 0;
        cmp_count = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = WORD_ZERO;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check_val("oe idle", 32'h0, {31'h0, byte_out_oe});
        check_val("carry idle", 32'h1, {31'h0, carry_out_a_n});
        rdr.pulse(9'h0C0);
        reg_expect(OFF_COUNT, 32'h0);
        $display("test reset_and_clear done");
        rdr.set_level(4, 1'b1);
        repeat (3) rdr.pulse(9'h080);
        repeat (2) rdr.pulse(9'h040);
        reg_expect(OFF_COUNT, 32'h0000_0003);
        rdr.set_level(5, 1'b0);
        repeat (2) rdr.pulse(9'h040);
        reg_expect(OFF_COUNT, 32'h0002_0003);
        check_val("carry", 32'h1, {31'h0, carry_out_a_n});
        $display("test counting done");
        rdr.pulse(9'h100);
        rdr.pulse(9'h080);
        for (int i = 0; i < 4; i++) begin
            rdr.read_byte(3 - i, bval);
            check_val("byte", {24'h0, exp_b[i]}, {24'h0, bval});
        end
        check_val("oe float", 32'h0, {31'h0, byte_out_oe});
        reg_expect(OFF_STORE, 32'h0002_0003);
        reg_expect(OFF_COUNT, 32'h0002_0004);
        $display("test capture_and_bytes done");
        rdr.chain_on <= 1'b1;
        repeat (2) rdr.pulse(9'h0C0);
        reg_expect(OFF_COUNT, 32'h0002_0006);
        rdr.chain_on <= 1'b0;
        $display("test chain done");
        rdr.set_level(4, 1'b0);
        rdr.pulse(9'h0C0);
        reg_expect(OFF_COUNT, 32'h0);
        reg_expect(OFF_STORE, 32'h0002_0003);
        rdr.set_level(4, 1'b1);
        rdr.pulse(9'h0C0);
        reg_expect(OFF_COUNT, 32'h0001_0001);
        $display("test clear done");
        axi_write(OFF_CTRL, 32'h2, rsp);
        check_val("write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        reg_expect(OFF_STORE, 32'h0001_0001);
        axi_write(OFF_CTRL, 32'h1, rsp);
        reg_expect(OFF_CTRL, 32'h1);
        reg_expect(OFF_STATUS, 32'h4);
        reg_expect(OFF_COUNT, 32'h0);
        axi_write(OFF_CTRL, 32'h0, rsp);
        // Byte lane 0 off: control write must be ignored
        s_axi_wstrb <= 4'hE;
        axi_write(OFF_CTRL, 32'h1, rsp);
        check_val("masked write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        reg_expect(OFF_CTRL, 32'h0);
        s_axi_wstrb <= 4'hF;
        axi_read(4'h2, rd, rsp);
        check_val("bad read resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        check_val("bad read data", 32'h0, rd);
        axi_write(4'h6, 32'h1, rsp);
        check_val("bad write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        $display("test register_bus done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
